// ---- rtl/fault_recorder_panel_control.sv ----
/*
 * Fault recorder and front-panel controller: pre-fault ring buffer, record
 * dump through an output FIFO, event queue, trip lamps and backlight timer.
 * Assumes trips, events and host commands come from logic on clk; keys and
 * the ADC word arrive from pins. Non-volatile storage sits downstream.
 */
`timescale 1ns/100ps

module wave_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp_q;
    logic [AW:0]  rp_q;

    assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign out_valid = wp_q != rp_q;
    assign out_data  = mem[rp_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (reset) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wp_q <= wp_q + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

module fault_recorder_panel_control
    import recorder_pkg::*;
#(
    parameter int BACKLIGHT_CYCLES = BACKLIGHT_CYC,
    parameter int SAMPLE_CYCLES    = SAMPLE_CYC,
    parameter int MS_CYCLES        = MS_CYC
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // front panel keys and converter, from pins
    input  wire logic [N_KEY-1:0]     key_raw,
    input  wire logic [SAMPLE_W-1:0]  adc_sample,
    output logic                      adc_start,
    // protection and supervision
    input  wire logic [N_ELEM-1:0]    trip_in,
    input  wire logic                 self_ok,
    input  wire logic [N_EXT_EVT-1:0] event_in,
    input  wire logic                 host_led_reset,
    input  wire logic                 time_set,
    input  wire logic [31:0]          time_value,
    input  wire logic                 settings_exit,
    // panel outputs
    output logic                      backlight_on,
    output logic [N_ELEM-1:0]         led_trip,
    output logic                      led_green,
    output logic                      led_amber,
    output logic                      settings_mode,
    output logic                      setting_up,
    output logic                      setting_down,
    output logic                      item_select,
    // waveform stream to storage
    output logic                      wave_valid,
    input  wire logic                 wave_ready,
    output wave_word_s                wave_data,
    // event stream to storage
    output logic                      evt_valid,
    input  wire logic                 evt_ready,
    output event_s                    evt_data,
    // record readout ports
    input  wire logic                 usb_rd_req,
    input  wire logic                 rs485_rd_req,
    input  wire logic                 rd_done,
    output logic                      rd_grant_usb,
    output logic                      rd_grant_rs485,
    // status
    output logic [7:0]                rec_count,
    output logic [12:0]               evt_count,
    output logic [31:0]               stamp_ms
);
    state_s              q;
    state_s              d;
    logic [SAMPLE_W-1:0] wave_mem [2**BUF_AW];
    logic [N_KEY-1:0]    key_edge;
    logic [N_ELEM-1:0]   trip_rise;
    logic                bl_start;
    logic                lamp_clear;
    logic                fifo_ready;
    logic [N_EVT-1:0]    evt_take;
    wave_word_s          push_word;

    function automatic logic [N_EVT-1:0] lowest_set(input logic [N_EVT-1:0] v);
        logic [N_EVT-1:0] r;
        r = v & (~v + 1'b1);
        return r;
    endfunction

    function automatic evt_code_e code_of(input logic [N_EVT-1:0] onehot);
        evt_code_e c;
        c = EVT_TRIP_CIRCUIT;
        for (int i = 0; i < N_EVT; i++) begin
            if (onehot[i]) begin
                c = evt_code_e'(4'(i));
            end
        end
        return c;
    endfunction

    assign key_edge   = q.key_s2 & ~q.key_prev;
    assign trip_rise  = trip_in & ~q.trip_prev;
    assign bl_start   = ((key_edge & ~(N_KEY'(1) << KEY_HRST)) != '0)
                        || (trip_rise != '0);
    assign lamp_clear = host_led_reset
                        || (key_edge[KEY_MENU] && (q.trip_led != '0));
    assign evt_take   = (!q.evt_valid || evt_ready) ? lowest_set(q.evt_pend) : '0;
    assign push_word  = '{slot: q.rec_slot, index: q.rec_idx, sample: wave_mem[q.rd_ptr]};

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        d = q;
        d.key_s1      = key_raw;
        d.key_s2      = q.key_s1;
        d.key_prev    = q.key_s2;
        d.adc_s1      = adc_sample;
        d.adc_s2      = q.adc_s1;
        d.trip_prev   = trip_in;
        d.healthy     = self_ok;
        d.setting_up  = 1'b0;
        d.setting_down = 1'b0;
        d.item_select = 1'b0;

        // backlight, reloaded on every qualifying press or trip
        if (bl_start) begin
            d.bl_cnt    = 32'(BACKLIGHT_CYCLES - 1);
            d.backlight = 1'b1;
        end else if (q.bl_cnt != '0) begin
            d.bl_cnt    = q.bl_cnt - 1'b1;
        end else begin
            d.backlight = 1'b0;
        end

        // lamps: a new trip beats a clear in the same cycle
        d.trip_led = (q.trip_led & ~{N_ELEM{lamp_clear}}) | trip_rise;

        // menu and settings keys
        if (settings_exit) begin
            d.settings_mode = 1'b0;
        end else if (key_edge[KEY_MENU] && (q.trip_led == '0)) begin
            if (q.settings_mode) begin
                d.item_select = 1'b1;
            end else begin
                d.settings_mode = 1'b1;
            end
        end
        if (q.settings_mode && (key_edge[KEY_INC] != key_edge[KEY_DEC])) begin
            d.setting_up   = key_edge[KEY_INC];
            d.setting_down = key_edge[KEY_DEC];
        end

        // sample pacing and millisecond clock
        d.sample_tick = 1'b0;
        if (q.samp_div == 32'(SAMPLE_CYCLES - 1)) begin
            d.samp_div    = '0;
            d.sample_tick = 1'b1;
        end else begin
            d.samp_div = q.samp_div + 1'b1;
        end
        if (time_set) begin
            d.stamp_ms = time_value;
            d.ms_div   = '0;
        end else if (q.ms_div == 32'(MS_CYCLES - 1)) begin
            d.ms_div   = '0;
            d.stamp_ms = q.stamp_ms + 1'b1;
        end else begin
            d.ms_div = q.ms_div + 1'b1;
        end
        if (q.sample_tick) begin
            d.wr_ptr = q.wr_ptr + 1'b1;
        end

        // fault capture for the trip event
        if (!q.faulted && (trip_rise != '0)) begin
            d.faulted       = 1'b1;
            d.fault_stamp   = q.stamp_ms;
            d.fault_current = q.adc_s2;
            d.fault_ms      = '0;
        end else if (q.faulted && (trip_in == '0)) begin
            d.faulted = 1'b0;
        end else if (q.faulted && (q.ms_div == 32'(MS_CYCLES - 1))) begin
            d.fault_ms = q.fault_ms + 1'b1;
        end

        // disturbance record
        unique case (q.rec_state)
            REC_IDLE: begin
                if (trip_rise != '0) begin
                    d.rec_state = REC_POST;
                    d.rec_idx   = '0;
                    d.rd_ptr    = q.wr_ptr - BUF_AW'(PRE_SAMPLES);
                end
            end
            REC_POST: begin
                if (q.sample_tick) begin
                    if (q.rec_idx == IDX_W'(POST_SAMPLES - 1)) begin
                        d.rec_state = REC_DUMP;
                        d.rec_idx   = '0;
                    end else begin
                        d.rec_idx = q.rec_idx + 1'b1;
                    end
                end
            end
            REC_DUMP: begin
                if (fifo_ready) begin
                    d.rd_ptr  = q.rd_ptr + 1'b1;
                    d.rec_idx = q.rec_idx + 1'b1;
                    if (q.rec_idx == IDX_W'(REC_SAMPLES - 1)) begin
                        d.rec_state = REC_IDLE;
                        d.rec_slot  = (q.rec_slot == 8'(MAX_RECORDS - 1)) ? '0
                                      : q.rec_slot + 1'b1;
                        if (q.rec_count != 8'(MAX_RECORDS)) begin
                            d.rec_count = q.rec_count + 1'b1;
                        end
                    end
                end
            end
            default: begin
                d.rec_state = REC_IDLE;
            end
        endcase

        // event queue: pending flags, raising wins over taking
        d.evt_pend = q.evt_pend & ~evt_take;
        d.evt_pend[N_EXT_EVT-1:0] = d.evt_pend[N_EXT_EVT-1:0] | event_in;
        if (q.setting_up || q.setting_down) begin
            d.evt_pend[EVT_SET_KEYPAD] = 1'b1;
        end
        if (q.faulted && (trip_in == '0)) begin
            d.evt_pend[EVT_ELEM_TRIP] = 1'b1;
        end
        if (q.evt_valid && evt_ready) begin
            d.evt_valid = 1'b0;
            d.evt_slot  = (q.evt_slot == 13'(MAX_EVENTS - 1)) ? '0
                          : q.evt_slot + 1'b1;
            if (q.evt_count != 13'(MAX_EVENTS)) begin
                d.evt_count = q.evt_count + 1'b1;
            end
        end
        if (evt_take != '0) begin
            d.evt_valid        = 1'b1;
            d.evt_out.code     = code_of(evt_take);
            d.evt_out.slot     = d.evt_slot;
            d.evt_out.stamp_ms = evt_take[EVT_ELEM_TRIP] ? q.fault_stamp : q.stamp_ms;
            d.evt_out.current  = evt_take[EVT_ELEM_TRIP] ? q.fault_current : '0;
            d.evt_out.clear_ms = evt_take[EVT_ELEM_TRIP] ? q.fault_ms : '0;
        end

        // one readout port at a time, USB first
        if (q.rd_grant == 2'b00) begin
            if (usb_rd_req) begin
                d.rd_grant = 2'b01;
            end else if (rs485_rd_req) begin
                d.rd_grant = 2'b10;
            end
        end else if (rd_done) begin
            d.rd_grant = 2'b00;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // ring keeps running during a dump; 448 spare words cover storage stalls
    always_ff @(posedge clk) begin
        if (q.sample_tick) begin
            wave_mem[q.wr_ptr] <= q.adc_s2;
        end
    end

    wave_fifo #(
        .W     ($bits(wave_word_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (q.rec_state == REC_DUMP),
        .in_ready  (fifo_ready),
        .in_data   (push_word),
        .out_valid (wave_valid),
        .out_ready (wave_ready),
        .out_data  (wave_data)
    );

    assign adc_start      = q.sample_tick;
    assign backlight_on   = q.backlight;
    assign led_trip       = q.trip_led;
    assign led_green      = q.healthy;
    assign led_amber      = ~q.healthy;
    assign settings_mode  = q.settings_mode;
    assign setting_up     = q.setting_up;
    assign setting_down   = q.setting_down;
    assign item_select    = q.item_select;
    assign evt_valid      = q.evt_valid;
    assign evt_data       = q.evt_out;
    assign rd_grant_usb   = q.rd_grant[0];
    assign rd_grant_rs485 = q.rd_grant[1];
    assign rec_count      = q.rec_count;
    assign evt_count      = q.evt_count;
    assign stamp_ms       = q.stamp_ms;

    ////////////////////////////////////////////////////////////////////////////

    property p_bl_key;
        @(posedge clk) disable iff (reset)
        (key_edge[KEY_MENU] || key_edge[KEY_INC]) |=> backlight_on;
    endproperty
    a_bl_key: assert property (p_bl_key) else $error("key did not light backlight");

    property p_bl_hrst;
        @(posedge clk) disable iff (reset)
        (!q.backlight && !bl_start && key_edge[KEY_HRST]) |=> !backlight_on;
    endproperty
    a_bl_hrst: assert property (p_bl_hrst) else $error("reset key lit backlight");

    property p_bl_off;
        @(posedge clk) disable iff (reset)
        (q.backlight && q.bl_cnt == '0 && !bl_start) |=> !backlight_on;
    endproperty
    a_bl_off: assert property (p_bl_off) else $error("backlight did not time out");

    property p_bl_trip;
        @(posedge clk) disable iff (reset)
        (trip_rise != '0) |=> backlight_on && q.bl_cnt == 32'(BACKLIGHT_CYCLES - 1);
    endproperty
    a_bl_trip: assert property (p_bl_trip) else $error("trip did not restart backlight");

    property p_menu_clear;
        @(posedge clk) disable iff (reset)
        (key_edge[KEY_MENU] && led_trip != '0 && trip_rise == '0) |=> led_trip == '0;
    endproperty
    a_menu_clear: assert property (p_menu_clear) else $error("menu did not clear trips");

    property p_tick;
        @(posedge clk) disable iff (reset)
        adc_start |=> !adc_start [*8];
    endproperty
    a_tick: assert property (p_tick) else $error("samples too close");

    property p_ring;
        @(posedge clk) disable iff (reset)
        adc_start |=> q.wr_ptr == $past(q.wr_ptr) + 1'b1;
    endproperty
    a_ring: assert property (p_ring) else $error("ring pointer did not advance");

    property p_led_set;
        @(posedge clk) disable iff (reset)
        (trip_rise != '0) |=> (led_trip & $past(trip_rise)) == $past(trip_rise);
    endproperty
    a_led_set: assert property (p_led_set) else $error("trip lamp not latched");

    property p_host_clr;
        @(posedge clk) disable iff (reset)
        (host_led_reset && trip_rise == '0) |=> led_trip == '0;
    endproperty
    a_host_clr: assert property (p_host_clr) else $error("host reset left lamps");

    property p_healthy;
        @(posedge clk) disable iff (reset)
        !self_ok |=> led_amber && !led_green;
    endproperty
    a_healthy: assert property (p_healthy) else $error("healthy lamp wrong");

    property p_step;
        @(posedge clk) disable iff (reset)
        (settings_mode && key_edge[KEY_INC] && !key_edge[KEY_DEC])
            |=> setting_up && !setting_down ##1 !setting_up;
    endproperty
    a_step: assert property (p_step) else $error("increment step missing");

    property p_rec_cap;
        @(posedge clk) disable iff (reset)
        rec_count <= 8'(MAX_RECORDS) && evt_count <= 13'(MAX_EVENTS);
    endproperty
    a_rec_cap: assert property (p_rec_cap) else $error("store count overflow");

    c_dump: cover property (@(posedge clk) disable iff (reset)
        q.rec_state == REC_POST ##1 q.rec_state == REC_DUMP);
    c_event: cover property (@(posedge clk) disable iff (reset)
        evt_valid && evt_ready && evt_data.code == EVT_ELEM_TRIP);
    c_bl_off: cover property (@(posedge clk) disable iff (reset)
        backlight_on ##1 !backlight_on);
endmodule

// ---- rtl/recorder_pkg.sv ----
/*
 * Shared constants, event codes, stream carriers and the state record of the
 * fault recorder and front-panel controller.
 * Assumes a 20 MHz system clock and a 50 Hz line.
 */
package recorder_pkg;

    // timing
    localparam int CLK_HZ            = 20_000_000;
    localparam int BACKLIGHT_S       = 20;
    localparam int BACKLIGHT_CYC     = CLK_HZ * BACKLIGHT_S;
    localparam int LINE_HZ           = 50;
    localparam int SAMPLES_PER_CYCLE = 32;
    localparam int SAMPLE_CYC        = CLK_HZ / (LINE_HZ * SAMPLES_PER_CYCLE);
    localparam int MS_PER_S          = 1000;
    localparam int MS_CYC            = CLK_HZ / MS_PER_S;

    // disturbance record geometry
    localparam int SAMPLE_W     = 16;
    localparam int PRE_CYCLES   = 45;
    localparam int POST_CYCLES  = 5;
    localparam int PRE_SAMPLES  = PRE_CYCLES * SAMPLES_PER_CYCLE;
    localparam int POST_SAMPLES = POST_CYCLES * SAMPLES_PER_CYCLE;
    localparam int REC_SAMPLES  = PRE_SAMPLES + POST_SAMPLES;
    localparam int BUF_AW       = 11;
    localparam int IDX_W        = 11;
    localparam int MAX_RECORDS  = 200;
    localparam int MAX_EVENTS   = 5000;
    localparam int FIFO_DEPTH   = 8;

    // panel
    localparam int N_ELEM    = 6;
    localparam int N_KEY     = 4;
    localparam int KEY_MENU  = 0;
    localparam int KEY_INC   = 1;
    localparam int KEY_DEC   = 2;
    localparam int KEY_HRST  = 3;
    localparam int N_EXT_EVT = 8;
    localparam int N_EVT     = 10;

    typedef enum logic [3:0] {
        EVT_TRIP_CIRCUIT = 4'h0,
        EVT_PICKUP       = 4'h1,
        EVT_RELAY_RESET  = 4'h2,
        EVT_CB_TRIP      = 4'h3,
        EVT_CB_CLOSE     = 4'h4,
        EVT_STATUS       = 4'h5,
        EVT_SET_HOST     = 4'h6,
        EVT_RELAY_FAIL   = 4'h7,
        EVT_SET_KEYPAD   = 4'h8,
        EVT_ELEM_TRIP    = 4'h9
    } evt_code_e;

    typedef enum logic [1:0] {
        REC_IDLE = 2'b00,
        REC_POST = 2'b01,
        REC_DUMP = 2'b10
    } rec_e;

    typedef struct packed {
        evt_code_e         code;
        logic [12:0]       slot;
        logic [31:0]       stamp_ms;
        logic [SAMPLE_W-1:0] current;
        logic [31:0]       clear_ms;
    } event_s;

    typedef struct packed {
        logic [7:0]          slot;
        logic [IDX_W-1:0]    index;
        logic [SAMPLE_W-1:0] sample;
    } wave_word_s;

    typedef struct packed {
        logic [N_KEY-1:0]    key_s1;
        logic [N_KEY-1:0]    key_s2;
        logic [N_KEY-1:0]    key_prev;
        logic [SAMPLE_W-1:0] adc_s1;
        logic [SAMPLE_W-1:0] adc_s2;
        logic [31:0]         bl_cnt;
        logic                backlight;
        logic [N_ELEM-1:0]   trip_led;
        logic [N_ELEM-1:0]   trip_prev;
        logic                healthy;
        logic                settings_mode;
        logic                setting_up;
        logic                setting_down;
        logic                item_select;
        logic [31:0]         samp_div;
        logic                sample_tick;
        logic [31:0]         ms_div;
        logic [31:0]         stamp_ms;
        logic [BUF_AW-1:0]   wr_ptr;
        logic [BUF_AW-1:0]   rd_ptr;
        logic [IDX_W-1:0]    rec_idx;
        rec_e                rec_state;
        logic [7:0]          rec_slot;
        logic [7:0]          rec_count;
        logic                faulted;
        logic [31:0]         fault_stamp;
        logic [31:0]         fault_ms;
        logic [SAMPLE_W-1:0] fault_current;
        logic [N_EVT-1:0]    evt_pend;
        event_s              evt_out;
        logic                evt_valid;
        logic [12:0]         evt_slot;
        logic [12:0]         evt_count;
        logic [1:0]          rd_grant;
    } state_s;

    localparam state_s STATE_RST = '0;

endpackage

// ---- bench/storage_host_model.sv ----
/*
 * Storage and host side model: drains the waveform and event streams.
 * Assumes ready may be dropped at any time; stall holds waveform off.
 */
`timescale 1ns/100ps

module storage_host_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // stream handshakes
    input  wire logic        stall,
    input  wire logic        wave_valid,
    input  wire logic        evt_valid,
    output logic             wave_ready,
    output logic             evt_ready,
    output logic [15:0]      wave_words
);
    logic [1:0] cnt_q;

    // slow and bursty readiness
    always_ff @(posedge clk) begin
        cnt_q      <= reset ? 2'h0 : cnt_q + 2'h1;
        wave_ready <= !reset && !stall && cnt_q != 2'h3;
        evt_ready  <= !reset && cnt_q[0];
        if (reset)
            wave_words <= 16'h0;
        else if (wave_valid && wave_ready)
            wave_words <= wave_words + 16'h1;
    end
endmodule

// ---- bench/test_fault_recorder_panel_control.sv ----
/*
 * Self-checking bench for the recorder and panel controller.
 * Assumes shortened timer parameters; inputs change on the falling edge.
 */
`timescale 1ns/100ps

module test_fault_recorder_panel_control;
    import recorder_pkg::*;
    logic clk = 0, reset = 1, self_ok = 1, host_led_reset = 0, time_set = 0, settings_exit = 0;
    logic usb_rd_req = 0, rs485_rd_req = 0, rd_done = 0, stall = 0, adc_start, backlight_on;
    logic [N_KEY-1:0] key_raw = '0;
    logic [SAMPLE_W-1:0] adc_sample = 16'h1234;
    logic [N_ELEM-1:0] trip_in = '0, led_trip;
    logic [N_EXT_EVT-1:0] event_in = '0;
    logic [31:0] time_value = 32'h0, stamp_ms;
    logic led_green, led_amber, settings_mode, setting_up, setting_down, item_select;
    logic wave_valid, wave_ready, evt_valid, evt_ready, rd_grant_usb, rd_grant_rs485;
    wave_word_s wave_data;
    event_s evt_data;
    logic [7:0] rec_count;
    logic [12:0] evt_count;
    logic [15:0] wave_words;
    int num_errors = 0, tests_run = 0, ticks = 0, ups = 0, downs = 0, sels = 0;
    int evts = 0, seen = 0, t0 = 0;
    evt_code_e got;
    logic [15:0] got_cur;
    evt_code_e rows[8] = '{EVT_TRIP_CIRCUIT, EVT_PICKUP, EVT_RELAY_RESET, EVT_CB_TRIP,
                           EVT_CB_CLOSE, EVT_STATUS, EVT_SET_HOST, EVT_RELAY_FAIL};

    fault_recorder_panel_control #(.BACKLIGHT_CYCLES(50), .SAMPLE_CYCLES(12), .MS_CYCLES(20))
    u_fault_recorder_panel_control (.clk, .reset, .key_raw, .adc_sample, .adc_start, .trip_in,
        .self_ok, .event_in, .host_led_reset, .time_set, .time_value, .settings_exit,
        .backlight_on, .led_trip, .led_green, .led_amber, .settings_mode, .setting_up,
        .setting_down, .item_select, .wave_valid, .wave_ready, .wave_data, .evt_valid,
        .evt_ready, .evt_data, .usb_rd_req, .rs485_rd_req, .rd_done, .rd_grant_usb,
        .rd_grant_rs485, .rec_count, .evt_count, .stamp_ms);
    storage_host_model u_storage_host_model (.clk, .reset, .stall, .wave_valid, .evt_valid,
        .wave_ready, .evt_ready, .wave_words);

    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        ticks <= ticks + (adc_start === 1'b1);
        ups   <= ups + (setting_up === 1'b1);
        downs <= downs + (setting_down === 1'b1);
        sels  <= sels + (item_select === 1'b1);
        // accepted events logged here, so one taken mid-press is not lost
        if (evt_valid === 1'b1 && evt_ready === 1'b1) begin
            evts    <= evts + 1;
            got     <= evt_data.code;
            got_cur <= evt_data.current;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic press(input int k);
        key_raw[k] = 1'b1;
        cyc(4);
        key_raw[k] = 1'b0;
        cyc(2);
    endtask
    // next accepted event; a missing one counts as a mismatch
    task automatic wait_evt(input evt_code_e c);
        for (int w = 0; w < 40 && evts == seen; w++)
            cyc(1);
        chk("evt_taken", seen + 1, evts);
        seen = evts;
        chk("evt_code", 32'(c), 32'(got));
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(20000);
        num_errors++;
        finish_test;
    end

    initial begin
        cyc(2);
        reset = 1'b0;
        chk("amber_rst", 1, led_amber);
        cyc(1);
        chk("green", 1, led_green);
        self_ok = 1'b0;
        cyc(2);
        chk("amber", 1, led_amber);
        self_ok = 1'b1;
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            event_in[i] = 1'b1;
            cyc(1);
            event_in[i] = 1'b0;
            wait_evt(rows[i]);
        end
        $display("event table done");
        t0 = ticks;
        cyc(120);
        chk("ticks", 10, ticks - t0);
        press(KEY_HRST);
        chk("bl_hrst", 0, backlight_on);
        press(KEY_INC);
        chk("bl_key", 1, backlight_on);
        cyc(30);
        press(KEY_DEC);
        cyc(40);
        chk("bl_restart", 1, backlight_on);
        cyc(20);
        chk("bl_off", 0, backlight_on);
        $display("backlight test done");
        stall = 1'b1;
        trip_in[2] = 1'b1;
        cyc(2);
        chk("lamp", 6'h04, led_trip);
        chk("bl_trip", 1, backlight_on);
        host_led_reset = 1'b1;
        cyc(1);
        host_led_reset = 1'b0;
        cyc(1);
        chk("lamp_clr", 0, led_trip);
        press(KEY_MENU);
        chk("settings", 1, settings_mode);
        trip_in[0] = 1'b1;
        cyc(2);
        press(KEY_MENU);
        chk("menu_clr", 0, led_trip);
        trip_in = '0;
        wait_evt(EVT_ELEM_TRIP);
        chk("evt_current", 16'h1234, got_cur);
        press(KEY_INC);
        chk("ups", 1, ups);
        wait_evt(EVT_SET_KEYPAD);
        press(KEY_DEC);
        wait_evt(EVT_SET_KEYPAD);
        chk("downs", 1, downs);
        press(KEY_MENU);
        chk("select", 1, sels);
        settings_exit = 1'b1;
        cyc(1);
        settings_exit = 1'b0;
        chk("exit", 0, settings_mode);
        chk("evt_count", 11, evt_count);
        $display("panel test done");
        cyc(2100);
        chk("stalled", 0, wave_words);
        stall = 1'b0;
        for (int w = 0; w < 3000 && wave_valid !== 1'b0; w++)
            cyc(1);
        chk("words", 1600, wave_words);
        chk("records", 1, rec_count);
        $display("record test done");
        usb_rd_req = 1'b1;
        cyc(2);
        chk("grant", 1, rd_grant_usb);
        rd_done = 1'b1;
        usb_rd_req = 1'b0;
        cyc(1);
        rd_done = 1'b0;
        cyc(1);
        chk("ungrant", 0, rd_grant_usb);
        rs485_rd_req = 1'b1;
        cyc(2);
        chk("grant485", 1, rd_grant_rs485);
        rs485_rd_req = 1'b0;
        time_value = 32'h1000;
        time_set = 1'b1;
        cyc(1);
        time_set = 1'b0;
        chk("stamp", 32'h1000, stamp_ms);
        $display("readout test done");
        finish_test;
    end
endmodule
